// ---- pin_select_pkg.sv ----
package pin_select_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_PINS = 26;
    localparam int NUM_IN_REGS = 9;
    localparam int NUM_OUT_REGS = 8;
    localparam int NUM_INPUTS = 14;
    localparam int SEL_W = 5;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;

    // ==========================================================
    // Register map, word index on the plain register port
    localparam logic [5:0] ADDR_IN_BASE = 6'h00;
    localparam logic [5:0] ADDR_OUT_BASE = 6'h10;
    localparam logic [5:0] ADDR_OSC_CTRL = 6'h20;
    localparam logic [5:0] ADDR_STATUS = 6'h21;

    // ==========================================================
    // Fields
    localparam int LO_FIELD_POS = 0;
    localparam int HI_FIELD_POS = 8;
    localparam int MAP_LOCK_BIT = 6;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

    // Which halves of the input selector registers are implemented.
    localparam logic [8:0] IN_LO_IMPL = 9'h1FE;
    localparam logic [8:0] IN_HI_IMPL = 9'h0DD;

    // ==========================================================
    // Codes
    localparam logic [4:0] IN_SEL_GROUND = 5'h1F;
    localparam logic [4:0] IN_SEL_RESET = 5'h1F;
    localparam logic [4:0] OUT_NULL = 5'h00;
    localparam logic [4:0] OUT_UART1_TX = 5'h03;
    localparam logic [4:0] OUT_UART1_RTS = 5'h04;
    localparam logic [4:0] OUT_SPI1_DO = 5'h07;
    localparam logic [4:0] OUT_SPI1_CLK = 5'h08;
    localparam logic [4:0] OUT_SPI1_SS = 5'h09;
    localparam logic [4:0] OUT_CMP1 = 5'h12;
    localparam logic [4:0] OUT_CMP2 = 5'h13;
    localparam logic [4:0] OUT_SEL_RESET = 5'h00;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_ONE = 3'b010,
        KEY_TWO = 3'b100
    } key_state_t;

    typedef struct packed {
        logic uart1_transmit;
        logic uart1_request_to_send;
        logic spi1_data_out;
        logic spi1_clock_out;
        logic spi1_select_out;
        logic compare1_output;
        logic compare2_output;
    } periph_out_t;

    typedef struct packed {
        logic ext_irq1_input;
        logic ext_irq2_input;
        logic timer2_ext_clock;
        logic timer3_ext_clock;
        logic capture1_input;
        logic capture2_input;
        logic capture7_input;
        logic capture8_input;
        logic compare_fault_a;
        logic uart1_receive;
        logic uart1_clear_to_send;
        logic spi1_data_in;
        logic spi1_clock_in;
        logic spi1_select_in;
    } periph_in_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : pin_select_pkg

// ---- remappable_pin_select.sv ----
// Behaviour
// - Input and output mapping are controlled by separate registers.
// - Each peripheral input has a 5-bit field choosing its pin.
// - Input code 11111 ties input low; code n selects pin n.
// - Input codes above the last pin also read as ground.
// - Fourteen peripheral inputs have selectors.
// - Input routing never overrides pin direction; software sets direction to input.
// - Each of the first sixteen pins has a 5-bit output code choosing its driving peripheral.
// - Output code 00000 leaves the pin to its port logic.
// - Codes 00011, 00100, 00111 select UART transmit, RTS, SPI data out.
// - Codes 01000, 01001, 10010, 10011 select SPI clock, select, compares.
// - While locked, selector writes are silently discarded.
// - Lock is bit 6 of the oscillator control register.
// - Lock changes only after keys 0x46 then 0x57 in the low byte.
// - Lock holds until the next accepted change.
// - Shadow copies are compared; any mismatch raises a reset request.
// - With one-way config set, the lock cannot be cleared once set.
// - One-way config defaults to set when unprogrammed.
// - Nine input and eight output selector registers exist.
// - Input register 0 holds external interrupt 1 in bits 12-8.
// - Implemented input fields reset to all ones.
// - Up to 26 remappable pins, numbered by selector code.
// - Direction one means input; all pins reset as inputs (here direction_reg is an input port; reset does not set it).
`timescale 1ns/100ps
module remappable_pin_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic one_way_lock_cfg,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [25:0] pin_in,
    input wire logic [25:0] port_out,
    input wire logic [25:0] port_oe,
    input wire logic [25:0] direction_reg,
    output logic [25:0] pin_out,
    output logic [25:0] pin_oe,
    input wire pin_select_pkg::periph_out_t periph_out,
    output pin_select_pkg::periph_in_t periph_in,
    output logic mismatch_reset
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [8:0][15:0] in_sel;
        logic [7:0][15:0] out_sel;
        logic [8:0][15:0] in_shadow;
        logic [7:0][15:0] out_shadow;
        logic [7:0] osc_low;
        logic map_lock;
        logic set_once;
        pin_select_pkg::key_state_t key;
        logic mismatch;
        logic [15:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;
    pin_select_pkg::reg_req_t req;

    // Fields not implemented in a register always read and store as zero.
    function automatic logic [15:0] in_mask(input int idx);
        logic [15:0] m;
        m = 16'h0000;
        if (pin_select_pkg::IN_LO_IMPL[idx]) begin
            m[pin_select_pkg::LO_FIELD_POS +: 5] = 5'h1F;
        end
        if (pin_select_pkg::IN_HI_IMPL[idx]) begin
            m[pin_select_pkg::HI_FIELD_POS +: 5] = 5'h1F;
        end
        return m;
    endfunction : in_mask

    // Codes beyond the pin count behave as the ground code.
    function automatic logic route_in(input logic [4:0] code, input logic [25:0] pins);
        logic v;
        v = 1'b0;
        if (code < 5'd26) begin
            v = pins[code];
        end
        return v;
    endfunction : route_in

    function automatic logic [4:0] in_field(input logic [8:0][15:0] r, input int idx,
                                            input int pos);
        return r[idx][pos +: 5];
    endfunction : in_field

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // ==========================================================
    // Next state
    always_comb begin
        logic osc_wr;
        logic sel_wr;
        logic [5:0] off;
        state_d = state_q;
        osc_wr = req.wr && (req.addr == pin_select_pkg::ADDR_OSC_CTRL);
        sel_wr = req.wr && !osc_wr;
        off = 6'h00;
        // Lock sequence: key one, key two, then exactly one lock write.
        case (state_q.key)
            pin_select_pkg::KEY_IDLE: begin
                if (osc_wr && req.wdata[7:0] == pin_select_pkg::UNLOCK_KEY1) begin
                    state_d.key = pin_select_pkg::KEY_ONE;
                end
            end
            pin_select_pkg::KEY_ONE: begin
                if (osc_wr && req.wdata[7:0] == pin_select_pkg::UNLOCK_KEY2) begin
                    state_d.key = pin_select_pkg::KEY_TWO;
                end else if (req.wr) begin
                    state_d.key = pin_select_pkg::KEY_IDLE;
                end
            end
            pin_select_pkg::KEY_TWO: begin
                if (osc_wr) begin
                    state_d.key = pin_select_pkg::KEY_IDLE;
                    state_d.osc_low = req.wdata[7:0];
                    // One-way mode keeps the lock set once it has been set.
                    if (req.wdata[pin_select_pkg::MAP_LOCK_BIT]) begin
                        state_d.map_lock = 1'b1;
                        state_d.set_once = 1'b1;
                    end else if (!(one_way_lock_cfg && state_q.set_once)) begin
                        state_d.map_lock = 1'b0;
                    end
                end else if (req.wr) begin
                    state_d.key = pin_select_pkg::KEY_IDLE;
                end
            end
            default: begin
                state_d.key = pin_select_pkg::KEY_IDLE;
            end
        endcase
        // Other bits of the low byte are plain storage; the lock bit is not touched here.
        if (osc_wr && state_q.key != pin_select_pkg::KEY_TWO) begin
            state_d.osc_low = req.wdata[7:0];
        end
        state_d.osc_low[pin_select_pkg::MAP_LOCK_BIT] = state_d.map_lock;

        if (sel_wr && !state_q.map_lock) begin
            for (int i = 0; i < pin_select_pkg::NUM_IN_REGS; i++) begin
                off = pin_select_pkg::ADDR_IN_BASE + 6'(i);
                if (req.addr == off) begin
                    state_d.in_sel[i] = req.wdata & in_mask(i);
                    state_d.in_shadow[i] = req.wdata & in_mask(i);
                end
            end
            for (int i = 0; i < pin_select_pkg::NUM_OUT_REGS; i++) begin
                off = pin_select_pkg::ADDR_OUT_BASE + 6'(i);
                if (req.addr == off) begin
                    state_d.out_sel[i] = req.wdata & 16'h1F1F;
                    state_d.out_shadow[i] = req.wdata & 16'h1F1F;
                end
            end
        end

        // Sticky until reset: the mismatch asks the reset controller to act.
        if (state_q.in_sel != state_q.in_shadow || state_q.out_sel != state_q.out_shadow) begin
            state_d.mismatch = 1'b1;
        end

        state_d.rdata = 16'h0000;
        if (req.rd) begin
            for (int i = 0; i < pin_select_pkg::NUM_IN_REGS; i++) begin
                if (req.addr == pin_select_pkg::ADDR_IN_BASE + 6'(i)) begin
                    state_d.rdata = state_q.in_sel[i];
                end
            end
            for (int i = 0; i < pin_select_pkg::NUM_OUT_REGS; i++) begin
                if (req.addr == pin_select_pkg::ADDR_OUT_BASE + 6'(i)) begin
                    state_d.rdata = state_q.out_sel[i];
                end
            end
            if (req.addr == pin_select_pkg::ADDR_OSC_CTRL) begin
                state_d.rdata = {8'h00, state_q.osc_low};
            end
            if (req.addr == pin_select_pkg::ADDR_STATUS) begin
                state_d.rdata = {12'h000, state_q.mismatch, state_q.set_once,
                                 one_way_lock_cfg, state_q.map_lock};
            end
        end
    end

    // ==========================================================
    // Input routing
    always_comb begin
        periph_in.ext_irq1_input = route_in(in_field(state_q.in_sel, 0, 8), pin_in);
        periph_in.ext_irq2_input = route_in(in_field(state_q.in_sel, 1, 0), pin_in);
        periph_in.timer2_ext_clock = route_in(in_field(state_q.in_sel, 2, 0), pin_in);
        periph_in.timer3_ext_clock = route_in(in_field(state_q.in_sel, 2, 8), pin_in);
        periph_in.capture1_input = route_in(in_field(state_q.in_sel, 3, 0), pin_in);
        periph_in.capture2_input = route_in(in_field(state_q.in_sel, 3, 8), pin_in);
        periph_in.capture7_input = route_in(in_field(state_q.in_sel, 4, 0), pin_in);
        periph_in.capture8_input = route_in(in_field(state_q.in_sel, 4, 8), pin_in);
        periph_in.compare_fault_a = route_in(in_field(state_q.in_sel, 5, 0), pin_in);
        periph_in.uart1_receive = route_in(in_field(state_q.in_sel, 6, 0), pin_in);
        periph_in.uart1_clear_to_send = route_in(in_field(state_q.in_sel, 6, 8), pin_in);
        periph_in.spi1_data_in = route_in(in_field(state_q.in_sel, 7, 0), pin_in);
        periph_in.spi1_clock_in = route_in(in_field(state_q.in_sel, 7, 8), pin_in);
        periph_in.spi1_select_in = route_in(in_field(state_q.in_sel, 8, 0), pin_in);
    end

    // ==========================================================
    // Output routing
    // Pins sample the pad regardless of routing; a set direction bit always stops
    // the pin driving, so a mapped input never fights a driver.
    always_comb begin
        logic [4:0] code;
        logic drive;
        code = 5'h00;
        drive = 1'b0;
        for (int p = 0; p < pin_select_pkg::NUM_PINS; p++) begin
            // Only the first sixteen pins own an output selector; the rest keep port logic.
            if (p < 2 * pin_select_pkg::NUM_OUT_REGS) begin
                code = state_q.out_sel[(p / 2) % pin_select_pkg::NUM_OUT_REGS][(p % 2) * 8 +: 5];
            end else begin
                code = pin_select_pkg::OUT_NULL;
            end
            drive = 1'b1;
            case (code)
                pin_select_pkg::OUT_UART1_TX: pin_out[p] = periph_out.uart1_transmit;
                pin_select_pkg::OUT_UART1_RTS: pin_out[p] = periph_out.uart1_request_to_send;
                pin_select_pkg::OUT_SPI1_DO: pin_out[p] = periph_out.spi1_data_out;
                pin_select_pkg::OUT_SPI1_CLK: pin_out[p] = periph_out.spi1_clock_out;
                pin_select_pkg::OUT_SPI1_SS: pin_out[p] = periph_out.spi1_select_out;
                pin_select_pkg::OUT_CMP1: pin_out[p] = periph_out.compare1_output;
                pin_select_pkg::OUT_CMP2: pin_out[p] = periph_out.compare2_output;
                default: begin
                    pin_out[p] = port_out[p];
                    drive = port_oe[p];
                end
            endcase
            pin_oe[p] = drive && !direction_reg[p];
        end
    end

    assign reg_rdata = state_q.rdata;
    assign mismatch_reset = state_q.mismatch;

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q.in_sel <= {16'h001F, 16'h1F1F, 16'h1F1F, 16'h001F,
                16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h001F, 16'h1F00};
            state_q.in_shadow <= {16'h001F, 16'h1F1F, 16'h1F1F, 16'h001F,
                16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h001F, 16'h1F00};
            state_q.out_sel <= '0;
            state_q.out_shadow <= '0;
            state_q.osc_low <= 8'h00;
            state_q.map_lock <= 1'b0;
            state_q.set_once <= 1'b0;
            state_q.key <= pin_select_pkg::KEY_IDLE;
            state_q.mismatch <= 1'b0;
            state_q.rdata <= 16'h0000;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : remappable_pin_select

// ---- remappable_pin_select_assertions.sv ----
`timescale 1ns/100ps
module remappable_pin_select_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic one_way_lock_cfg,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [25:0] pin_in,
    input wire logic [25:0] port_out,
    input wire logic [25:0] port_oe,
    input wire logic [25:0] direction_reg,
    input wire logic [25:0] pin_out,
    input wire logic [25:0] pin_oe,
    input wire pin_select_pkg::periph_out_t periph_out,
    input wire pin_select_pkg::periph_in_t periph_in,
    input wire logic mismatch_reset
);
    // ==========
    // Port relations
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the read slot");
    a_oe_input: assert property ((pin_oe & direction_reg) == 26'h0)
        else $error("pin driven while direction is input");
    a_mismatch_quiet: assert property (mismatch_reset == 1'b0)
        else $error("mismatch reset without a disturbance");
    a_reg0_unimpl: assert property ($past(reg_rd && reg_addr == 6'h00) |->
        reg_rdata[15:13] == 3'h0 && reg_rdata[7:0] == 8'h00) else $error("input reg 0 spare bits");
    a_reg1_unimpl: assert property ($past(reg_rd && reg_addr == 6'h01) |->
        reg_rdata[15:5] == 11'h000) else $error("input reg 1 spare bits");
    a_in_width: assert property ($past(reg_rd && reg_addr <= 6'h08) |->
        reg_rdata[15:13] == 3'h0 && reg_rdata[7:5] == 3'h0) else $error("input field too wide");
    a_out_width: assert property ($past(reg_rd && reg_addr[5:3] == 3'b010) |->
        reg_rdata[15:13] == 3'h0 && reg_rdata[7:5] == 3'h0) else $error("output field too wide");
    a_unmapped_zero: assert property ($past(reg_rd && reg_addr == 6'h30) |->
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_reset_ground: assert property (!$past(rst_n) |->
        periph_in == '0 && pin_out == port_out) else $error("routing not at reset state");
endmodule : remappable_pin_select_checker

bind remappable_pin_select remappable_pin_select_checker checker_inst (.*);

// ---- periph_model.sv ----
`timescale 1ns/100ps
module periph_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic [25:0] pin_in,
    output pin_select_pkg::periph_out_t periph_out
);
    // ==========
    // Pad and peripheral activity
    // An inverting rotation shifts and flips the pattern every cycle, so a wrong pick shows quickly.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_in <= 26'h1234567;
            periph_out <= 7'h35;
        end else begin
            pin_in <= ~{pin_in[0], pin_in[25:1]};
            periph_out <= ~{periph_out[0], periph_out[6:1]};
        end
    end
endmodule : periph_model

// ---- test_remappable_pin_select.sv ----
`timescale 1ns/100ps
module test_remappable_pin_select;
    // ==========
    // Wiring
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic one_way_lock_cfg = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [25:0] pin_in;
    logic [25:0] port_out = 26'h1555555;
    logic [25:0] port_oe = 26'h3FFFFFF;
    logic [25:0] direction_reg = 26'h20000A1;
    logic [25:0] pin_out;
    logic [25:0] pin_oe;
    pin_select_pkg::periph_out_t periph_out;
    pin_select_pkg::periph_in_t periph_in;
    logic mismatch_reset;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [4:0] in_codes [5] = '{5'h00, 5'h05, 5'h19, 5'h1E, 5'h1F};
    logic [4:0] out_codes [8] = '{5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13, 5'h05};

    remappable_pin_select dut (.*);
    periph_model partner (.*);

    always #2.5 clk = ~clk;

    // ==========
    // Access tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    // The key pair must be followed directly by the lock step, so no write may slip between.
    task key(input logic [15:0] v);
        wr(6'h20, 16'h0046);
        wr(6'h20, 16'h0057);
        wr(6'h20, v);
    endtask : key

    task tally_and_finish;
        $display("errors %0d, comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ==========
    // Scenarios
    initial begin
        int i;
        int j;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(6'h00, 16'h1F00);
        rd(6'h01, 16'h001F);
        rd(6'h10, 16'h0000);
        for (i = 0; i < 5; i++) begin
            wr(6'h00, {3'b000, in_codes[i], 8'h00});
            for (j = 0; j < 6; j++) begin
                @(negedge clk);
                chk(periph_in.ext_irq1_input, in_codes[i] < 5'd26 ? pin_in[in_codes[i]] : 1'b0);
            end
        end
        wr(6'h03, 16'h0719);
        @(negedge clk);
        chk({periph_in.capture1_input, periph_in.capture2_input}, {pin_in[25], pin_in[7]});
        rd(6'h03, 16'h0719);
        direction_reg <= 26'h20000A0;
        for (i = 0; i < 8; i++) begin
            wr(6'h10, {11'h000, out_codes[i]});
            @(negedge clk);
            chk(pin_out[1:0], {port_out[1], i < 7 ? periph_out[6 - i] : port_out[0]});
        end
        wr(6'h10, 16'h0000);
        @(negedge clk);
        chk(pin_out, port_out);
        wr(6'h10, 16'h0003);
        direction_reg <= 26'h20000A1;
        @(negedge clk);
        chk(pin_oe[0], 1'b0);
        rd(6'h10, 16'h0003);
        wr(6'h00, 16'hFFFF);
        rd(6'h00, 16'h1F00);
        key(16'h0040);
        rd(6'h21, 16'h0005);
        wr(6'h00, 16'h0300);
        rd(6'h00, 16'h1F00);
        wr(6'h20, 16'h0046);
        wr(6'h10, 16'h0000);
        wr(6'h20, 16'h0057);
        wr(6'h20, 16'h0000);
        rd(6'h21, 16'h0005);
        key(16'h0000);
        rd(6'h21, 16'h0004);
        wr(6'h00, 16'h0200);
        wr(6'h03, 16'h0102);
        rd(6'h00, 16'h0200);
        rd(6'h03, 16'h0102);
        wr(6'h06, 16'h0203);
        @(negedge clk);
        chk({periph_in.uart1_receive, periph_in.uart1_clear_to_send}, {pin_in[3], pin_in[2]});
        one_way_lock_cfg <= 1'b1;
        key(16'h0040);
        key(16'h0000);
        rd(6'h21, 16'h0007);
        wr(6'h00, 16'h0900);
        rd(6'h00, 16'h0200);
        rd(6'h30, 16'h0000);
        chk(mismatch_reset, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(6'h00, 16'h1F00);
        tally_and_finish();
    end
endmodule : test_remappable_pin_select
